// ### hdl/pdmc_cfg.sv
`timescale 1ns/1ps
module pdmc_cfg
    import pdmc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic auto_detect_en,
    output logic [7:0] reg_rdata,
    output logic [8:0] prescale_out,
    output logic [8:0] int_mult_out,
    output logic [13:0] frac_mult_out,
    output logic divided_clock_halve,
    output logic [3:0] n_out,
    output logic [4:0] pdm_out,
    output logic cfg_error
);
    logic [7:0] pre_q, up_q, fl_q, il_q, np_q;
    logic [8:0] pv, iv;
    logic [13:0] fv;
    logic [3:0] nv;
    logic [4:0] dv;
    logic ib, fb, pb;

    wire sel_pre = reg_addr == PDMC_OFS_PRESCALE;
    wire sel_up = reg_addr == PDMC_OFS_MULT_UPPER;
    wire sel_fl = reg_addr == PDMC_OFS_FRAC_LOW;
    wire sel_il = reg_addr == PDMC_OFS_INT_LOW;
    wire sel_np = reg_addr == PDMC_OFS_NPDM;
    // Unmapped offsets read zero
    wire [7:0] rd_mux = sel_pre ? pre_q : sel_up ? up_q : sel_fl ? fl_q :
                        sel_il ? il_q : sel_np ? (np_q & PDMC_NPDM_WMASK) : 8'h00;
    wire auto_q_sync;
    logic auto_s1, auto_s2;
    assign auto_q_sync = auto_s2;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= PDMC_RST_PRESCALE;
            up_q <= PDMC_RST_MULT_UPPER;
            fl_q <= PDMC_RST_FRAC_LOW;
            il_q <= PDMC_RST_INT_LOW;
            np_q <= PDMC_RST_NPDM;
        end else if (reg_wr) begin
            if (sel_pre) pre_q <= reg_wdata;
            if (sel_up) up_q <= reg_wdata;
            if (sel_fl) fl_q <= reg_wdata;
            if (sel_il) il_q <= reg_wdata;
            // Reserved bits stay at reset value whatever is written
            if (sel_np) np_q <= reg_wdata & PDMC_NPDM_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            auto_s1 <= 1'b0;
            auto_s2 <= 1'b0;
        end else begin
            auto_s1 <= auto_detect_en;
            auto_s2 <= auto_s1;
        end
    end

    pdmc_decode u_dec (
        .prescale_ratio(pre_q),
        .mult_upper(up_q),
        .fraction_mult_low_byte(fl_q),
        .integer_mult_low_byte(il_q),
        .npdm(np_q),
        .prescale_val(pv),
        .int_val(iv),
        .frac_val(fv),
        .n_val(nv),
        .pdm_val(dv),
        .int_bad(ib),
        .frac_bad(fb),
        .pdm_bad(pb)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            prescale_out <= PDMC_AUTO_PRESCALE;
            int_mult_out <= PDMC_AUTO_INT;
            frac_mult_out <= PDMC_AUTO_FRAC;
            divided_clock_halve <= 1'b0;
            n_out <= PDMC_AUTO_N;
            pdm_out <= PDMC_AUTO_PDM;
            cfg_error <= 1'b0;
        end else begin
            if (reg_rd) reg_rdata <= rd_mux;
            // Halving is not among the fields auto detection overrides
            divided_clock_halve <= up_q[PDMC_HALVE_BIT];
            if (auto_q_sync) begin
                prescale_out <= PDMC_AUTO_PRESCALE;
                int_mult_out <= PDMC_AUTO_INT;
                frac_mult_out <= PDMC_AUTO_FRAC;
                n_out <= PDMC_AUTO_N;
                pdm_out <= PDMC_AUTO_PDM;
                cfg_error <= 1'b0;
            end else begin
                prescale_out <= pv;
                int_mult_out <= iv;
                frac_mult_out <= fv;
                n_out <= nv;
                pdm_out <= dv;
                cfg_error <= ib | fb | pb;
            end
        end
    end

    // Field views used only by the checks below
    wire [2:0] n_code = np_q[PDMC_N_MSB:PDMC_N_LSB];
    wire [2:0] pdm_code = np_q[PDMC_PDM_MSB:PDMC_PDM_LSB];
    wire [8:0] int_code = {up_q[PDMC_INT_TOP_BIT], il_q};
    wire [13:0] frac_code = {up_q[PDMC_FRAC_UP_MSB:0], fl_q};
    wire codes_legal = (int_code != 9'h000) && (frac_code <= PDMC_FRAC_MAX)
                       && (pdm_code <= PDMC_PDM_MAX_CODE);
    wire sel_none = !(sel_pre || sel_up || sel_fl || sel_il || sel_np);

    sequence manual_s;
        !auto_q_sync;
    endsequence

    // Auto detection must stand through both sync stages before outputs follow
    sequence auto_hold_s;
        auto_detect_en ##1 auto_detect_en ##1 auto_detect_en;
    endsequence

    sequence manual_hold_s;
        !auto_detect_en ##1 !auto_detect_en ##1 !auto_detect_en;
    endsequence

    // A write lands one edge later and reaches the output one edge after that
    sequence pre_write_s;
        (reg_wr && sel_pre) ##1 manual_s;
    endsequence

    sequence up_write_s;
        (reg_wr && sel_up) ##1 manual_s;
    endsequence

    sequence fl_write_s;
        (reg_wr && sel_fl) ##1 manual_s;
    endsequence

    sequence int_low_write_s;
        (reg_wr && sel_il) ##1 manual_s;
    endsequence

    AST_PRESCALE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && pre_q == 8'h00) |=> (prescale_out == PDMC_PRESCALE_ZERO_RATIO))
        else $error("prescale code zero not 256");
    AST_AUTO_OVERRIDE: assert property (@(posedge mclk) disable iff (!rstn)
        auto_q_sync |=> (int_mult_out == PDMC_AUTO_INT && n_out == PDMC_AUTO_N))
        else $error("auto detect did not override");
    AST_INT_JOIN: assert property (@(posedge mclk) disable iff (!rstn)
        !auto_q_sync |=> (int_mult_out == {$past(up_q[PDMC_INT_TOP_BIT]), $past(il_q)}))
        else $error("integer multiplier join wrong");
    AST_INT_ZERO_FLAG: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && int_code == 9'h000) |=> cfg_error)
        else $error("zero integer not flagged");
    AST_FRAC_JOIN: assert property (@(posedge mclk) disable iff (!rstn)
        !auto_q_sync |=> (frac_mult_out == {$past(up_q[PDMC_FRAC_UP_MSB:0]), $past(fl_q)}))
        else $error("fraction join wrong");
    AST_FRAC_RANGE: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && frac_code > PDMC_FRAC_MAX) |=> cfg_error)
        else $error("reserved fraction not flagged");
    AST_HALVE: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && sel_up) |-> ##2 (divided_clock_halve == $past(reg_wdata[PDMC_HALVE_BIT], 2)))
        else $error("halve bit not followed");
    AST_N_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && n_code == 3'h0) |=> (n_out == PDMC_N_ZERO_RATIO))
        else $error("n code zero not 8");
    AST_PDM_RATIO: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && pdm_code == 3'h3) |=> (pdm_out == 5'h08))
        else $error("pdm code 3 not 8");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && sel_np) |=> (reg_rdata[1:0] == 2'h0))
        else $error("reserved bits read nonzero");

    AST_PRESCALE_CODE: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && pre_q != 8'h00) |=> (prescale_out == {1'h0, $past(pre_q)}))
        else $error("prescale code not passed through");
    AST_PRESCALE_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        pre_write_s |=> (prescale_out[7:0] == $past(reg_wdata, 2)))
        else $error("prescale write not reflected");
    AST_AUTO_ENTER: assert property (@(posedge mclk) disable iff (!rstn)
        auto_hold_s |=> (prescale_out == PDMC_AUTO_PRESCALE && frac_mult_out == PDMC_AUTO_FRAC
                         && pdm_out == PDMC_AUTO_PDM && !cfg_error))
        else $error("auto detect left programmed ratios");
    AST_AUTO_LEAVE: assert property (@(posedge mclk) disable iff (!rstn)
        manual_hold_s |=> (frac_mult_out == $past(frac_code) && prescale_out[7:0] == $past(pre_q)))
        else $error("programmed ratios not restored");
    AST_INT_TOP_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        up_write_s |=> (int_mult_out[8] == $past(reg_wdata[PDMC_INT_TOP_BIT], 2)))
        else $error("integer top bit write not reflected");
    AST_INT_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        int_low_write_s |=> (int_mult_out[7:0] == $past(reg_wdata, 2)))
        else $error("integer low byte write not reflected");
    AST_LEGAL_NO_ERROR: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && codes_legal) |=> !cfg_error)
        else $error("legal codes flagged as error");
    AST_FRAC_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
        fl_write_s |=> (frac_mult_out[7:0] == $past(reg_wdata, 2)))
        else $error("fraction low byte write not reflected");
    AST_HALVE_IN_AUTO: assert property (@(posedge mclk) disable iff (!rstn)
        auto_q_sync |=> (divided_clock_halve == $past(up_q[PDMC_HALVE_BIT])))
        else $error("halve bit lost in auto mode");
    AST_N_CODE: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && n_code != 3'h0) |=> (n_out == {1'h0, $past(n_code)}))
        else $error("n code not passed through");
    AST_PDM_BASE: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && pdm_code == 3'h0) |=> (pdm_out == 5'h01))
        else $error("pdm code 0 not 1");
    AST_PDM_RSVD: assert property (@(posedge mclk) disable iff (!rstn)
        (!auto_q_sync && pdm_code > PDMC_PDM_MAX_CODE) |=> (pdm_out == 5'h10 && cfg_error))
        else $error("reserved pdm code not saturated and flagged");
    AST_NPDM_WR_MASK: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && sel_np) |=> (np_q[1:0] == 2'h0))
        else $error("reserved bits stored nonzero");
    AST_UNMAPPED_RD: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && sel_none) |=> (reg_rdata == 8'h00))
        else $error("unmapped offset read nonzero");
    AST_RD_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule

// ### hdl/pdmc_pkg.sv
// Function
// - Prescale code 0 means 256, else code
// - Auto detect overrides all programmed ratios; the code still passes halve bit 6 through in auto mode
// - Integer multiplier: top bit plus low byte
// - Integer multiplier equals code; zero reserved
// - Fraction: six upper bits plus low byte
// - Fraction equals code; above 9999 reserved
// - Halve control bit 6 halves divided clock
// - N ratio code 0 means 8
// - PDM ratio codes 0-4 give 1..16
// - Reserved bits 1-0 read zero
package pdmc_pkg;
    localparam logic [7:0] PDMC_OFS_PRESCALE = 8'h35;
    localparam logic [7:0] PDMC_OFS_MULT_UPPER = 8'h36;
    localparam logic [7:0] PDMC_OFS_FRAC_LOW = 8'h37;
    localparam logic [7:0] PDMC_OFS_INT_LOW = 8'h38;
    localparam logic [7:0] PDMC_OFS_NPDM = 8'h39;
    localparam logic [7:0] PDMC_RST_PRESCALE = 8'h01;
    localparam logic [7:0] PDMC_RST_MULT_UPPER = 8'h00;
    localparam logic [7:0] PDMC_RST_FRAC_LOW = 8'h00;
    localparam logic [7:0] PDMC_RST_INT_LOW = 8'h08;
    localparam logic [7:0] PDMC_RST_NPDM = 8'h20;
    localparam int PDMC_INT_TOP_BIT = 7;
    localparam int PDMC_HALVE_BIT = 6;
    localparam int PDMC_FRAC_UP_MSB = 5;
    localparam int PDMC_N_MSB = 7;
    localparam int PDMC_N_LSB = 5;
    localparam int PDMC_PDM_MSB = 4;
    localparam int PDMC_PDM_LSB = 2;
    localparam logic [7:0] PDMC_NPDM_WMASK = 8'hFC;
    localparam logic [8:0] PDMC_PRESCALE_ZERO_RATIO = 9'h100;
    localparam logic [3:0] PDMC_N_ZERO_RATIO = 4'h8;
    localparam logic [13:0] PDMC_FRAC_MAX = 14'h270F;
    localparam logic [2:0] PDMC_PDM_MAX_CODE = 3'h4;
    // Ratios used while auto detection owns the clock tree
    localparam logic [8:0] PDMC_AUTO_PRESCALE = 9'h001;
    localparam logic [8:0] PDMC_AUTO_INT = 9'h008;
    localparam logic [13:0] PDMC_AUTO_FRAC = 14'h0000;
    localparam logic [3:0] PDMC_AUTO_N = 4'h1;
    localparam logic [4:0] PDMC_AUTO_PDM = 5'h01;
endpackage

// ### hdl/pdmc_decode.sv
`timescale 1ns/1ps
module pdmc_decode
    import pdmc_pkg::*;
(
    input wire logic [7:0] prescale_ratio,
    input wire logic [7:0] mult_upper,
    input wire logic [7:0] fraction_mult_low_byte,
    input wire logic [7:0] integer_mult_low_byte,
    input wire logic [7:0] npdm,
    output logic [8:0] prescale_val,
    output logic [8:0] int_val,
    output logic [13:0] frac_val,
    output logic [3:0] n_val,
    output logic [4:0] pdm_val,
    output logic int_bad,
    output logic frac_bad,
    output logic pdm_bad
);
    wire [2:0] n_ratio = npdm[PDMC_N_MSB:PDMC_N_LSB];
    wire [2:0] pdm_clock_ratio = npdm[PDMC_PDM_MSB:PDMC_PDM_LSB];
    wire integer_mult_top_bit = mult_upper[PDMC_INT_TOP_BIT];
    wire [5:0] fraction_mult_upper = mult_upper[PDMC_FRAC_UP_MSB:0];
    assign prescale_val = (prescale_ratio == 8'h00) ? PDMC_PRESCALE_ZERO_RATIO
                          : {1'b0, prescale_ratio};
    assign int_val = {integer_mult_top_bit, integer_mult_low_byte};
    assign int_bad = (int_val == 9'h000);
    assign frac_val = {fraction_mult_upper, fraction_mult_low_byte};
    assign frac_bad = (frac_val > PDMC_FRAC_MAX);
    assign n_val = (n_ratio == 3'h0) ? PDMC_N_ZERO_RATIO : {1'b0, n_ratio};
    // Reserved codes saturate at the largest ratio rather than wrap
    assign pdm_bad = (pdm_clock_ratio > PDMC_PDM_MAX_CODE);
    assign pdm_val = pdm_bad ? 5'h10 : 5'(5'h01 << pdm_clock_ratio);
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
    import pdmc_pkg::*;
    logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, auto_detect_en = 0, rd_seen = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
    logic [8:0] prescale_out, int_mult_out;
    logic [13:0] frac_mult_out;
    logic divided_clock_halve, cfg_error;
    logic [3:0] n_out;
    logic [4:0] pdm_out;
    int fails = 0, tests_run = 0;
    logic [7:0] m [5];
    logic [7:0] rq [$];
    logic [42:0] oq [$];
    pdmc_cfg dut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .auto_detect_en(auto_detect_en),
        .reg_rdata(reg_rdata), .prescale_out(prescale_out), .int_mult_out(int_mult_out),
        .frac_mult_out(frac_mult_out), .divided_clock_halve(divided_clock_halve),
        .n_out(n_out), .pdm_out(pdm_out), .cfg_error(cfg_error));
    always #5 mclk = ~mclk;
    function automatic logic [42:0] model();
        logic [8:0] p, j;
        logic [13:0] d;
        logic [3:0] n;
        logic [4:0] q;
        logic [2:0] c;
        logic e;
        p = (m[0] == 8'h00) ? 9'h100 : {1'b0, m[0]};
        j = {m[1][7], m[3]};
        d = {m[1][5:0], m[2]};
        n = (m[4][7:5] == 3'h0) ? 4'h8 : {1'b0, m[4][7:5]};
        c = m[4][4:2];
        q = (c > 3'h4) ? 5'h10 : 5'h01 << c;
        e = (j == 9'h000) || (d > 14'h270F) || (c > 3'h4);
        if (auto_detect_en) begin
            {p, j, d, n, q, e} = {PDMC_AUTO_PRESCALE, PDMC_AUTO_INT, PDMC_AUTO_FRAC,
                                  PDMC_AUTO_N, PDMC_AUTO_PDM, 1'h0};
        end
        return {p, j, d, m[1][6], n, q, e};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 0;
        if (a >= 8'h35 && a <= 8'h39) m[a - 8'h35] = (a == 8'h39) ? (d & 8'hFC) : d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1;
        reg_addr <= a;
        rq.push_back(e);
        @(posedge mclk);
        reg_rd <= 0;
    endtask
    // Margin covers the input sync and output register stages
    task automatic chk_out();
        repeat (4) @(posedge mclk);
        oq.push_back(model());
    endtask
    task automatic conclude();
        if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge mclk) rd_seen <= reg_rd;
    always @(negedge mclk) begin
        logic [7:0] er;
        logic [42:0] eo;
        if (rd_seen) begin
            er = rq.pop_front();
            `CHK(reg_rdata, er)
        end
        while (oq.size() > 0) begin
            eo = oq.pop_front();
            `CHK({prescale_out, int_mult_out, frac_mult_out, divided_clock_halve,
                n_out, pdm_out, cfg_error}, eo)
        end
    end
    initial begin
        #200000;
        fails++;
        conclude();
    end
    initial begin
        logic [7:0] a, d;
        void'($urandom(32'hbb652d16));
        m = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h20};
        repeat (10) @(posedge mclk);
        rstn <= 1;
        chk_out();
        for (int i = 0; i < 5; i++) rd(8'(8'h35 + i), m[i]);
        wr(8'h3A, 8'h55);
        rd(8'h3A, 8'h00);
        rd(8'h34, 8'h00);
        wr(8'h39, 8'hFF);
        rd(8'h39, 8'hFC);
        chk_out();
        // Legal divider codes again, so later error checks isolate one field
        wr(8'h39, 8'h20);
        wr(8'h35, 8'h00);
        chk_out();
        wr(8'h35, 8'hFF);
        wr(8'h36, 8'hFF);
        wr(8'h38, 8'hFF);
        wr(8'h37, 8'hFF);
        chk_out();
        wr(8'h36, 8'h27);
        wr(8'h37, 8'h0F);
        chk_out();
        wr(8'h37, 8'h10);
        chk_out();
        wr(8'h36, 8'h00);
        wr(8'h38, 8'h00);
        chk_out();
        wr(8'h38, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(8'h39, 8'(c * 36));
            chk_out();
        end
        wr(8'h36, 8'hC5);
        @(posedge mclk);
        auto_detect_en <= 1;
        chk_out();
        wr(8'h35, 8'h07);
        chk_out();
        rd(8'h35, 8'h07);
        @(posedge mclk);
        auto_detect_en <= 0;
        chk_out();
        repeat (20) begin
            a = 8'h35 + 8'($urandom_range(4));
            d = 8'($urandom);
            wr(a, (a == 8'h39) ? (d & 8'hFC) : d);
            rd(a, m[a - 8'h35]);
        end
        chk_out();
        @(posedge mclk);
        rstn <= 0;
        @(posedge mclk);
        rstn <= 1;
        m = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h20};
        chk_out();
        // Let the checker take the last note before the run ends
        repeat (2) @(posedge mclk);
        conclude();
    end
endmodule
